/* hw/sep_defs.svh */
// Shared constants of the serial EEPROM protection controller
`ifndef SEP_DEFS_SVH
`define SEP_DEFS_SVH

// Instruction codes
`define SEP_OP_ARM 8'h06
`define SEP_OP_DISARM 8'h04
`define SEP_OP_FETCH 8'h05
`define SEP_OP_LOAD 8'h01
`define SEP_OP_READ 8'h03
`define SEP_OP_WRITE 8'h02

// Status register field positions
`define SEP_SR_BUSY 0
`define SEP_SR_ARM 1
`define SEP_SR_GLO 2
`define SEP_SR_GHI 3
`define SEP_SR_LOCK 7

// Guard codes and first protected address of each
`define SEP_GUARD_NONE 2'b00
`define SEP_GUARD_QTR 2'b01
`define SEP_GUARD_HALF 2'b10
`define SEP_GUARD_ALL 2'b11
`define SEP_BASE_QTR 16'hc000
`define SEP_BASE_HALF 16'h8000
`define SEP_BASE_ALL 16'h0000

// Framing counts
`define SEP_BIT_LAST 3'h7
`define SEP_BIT_FIRST 3'h1
`define SEP_BYTES_NONE 3'h0
`define SEP_BYTES_OP 3'h1
`define SEP_BYTES_LOAD 3'h2
`define SEP_BYTES_ADDR_LO 3'h2
`define SEP_BYTES_WRITE 3'h4
`define SEP_BYTES_SAT 3'h4
`define SEP_OIDX_FIRST 3'h7
`define SEP_BIT_ZERO 3'h0

// Reset values
`define SEP_GUARD_RST 2'b00
`define SEP_LOCK_RST 1'b0
`define SEP_BYTE_RST 8'h00
`define SEP_ADDR_RST 16'h0000

// Self-timed cycle length in core cycles (arbitrary default)
`define SEP_TW_CYCLES 1000

`endif

/* hw/sep_pkg.sv */
// Types of the serial EEPROM protection controller
package sep_pkg;

  typedef enum logic [0:0] {
    SEP_IDLE = 1'b0,
    SEP_BUSY = 1'b1
  } sep_state_t;

  // Frame as collected on the link side
  typedef struct packed {
    logic [7:0] op;
    logic [15:0] addr;
    logic [7:0] dat;
    logic [2:0] bit_cnt;
    logic [2:0] byte_cnt;
  } sep_frame_t;

  // Levels crossing into the core domain
  typedef struct packed {
    logic cs_n;
    logic sclk;
    logic hold_n;
    logic wp_n;
    logic tog;
    logic oen;
    logic [2:0] ogray;
  } sep_sync_t;

endpackage

/* hw/sep_ctrl.sv */
// Serial EEPROM select, pause, status and protection control
`timescale 1ns/1ps
`default_nettype none
`include "sep_defs.svh"
// Functional notes
// - Stay unselected until first chip-select fall
// - Ignore all instructions during power-on reset
// - Deselected when high; standby only if idle
// - Paused: output floats, clock and data ignored
// - Pause only while selected
// - Pause starts: hold low, clock low
// - Pause ends: hold high, clock low
// - Pause keeps bit position for resuming
// - Deselect during pause resets interface state
// - Status holds busy flag for write cycles
// - Status mirrors the arm latch
// - Guard bits choose read-only upper region
// - Pin guard mode freezes lock and guards
// - Writes need whole multiple of eight clocks
// - Modifying instructions need arm latch set
// - Arm cleared at reset, disarm, write completion
// - Execute only on release after final bit
// - Final bit is opcode or last data
// - First byte is the opcode
// - Unknown opcode: ignore bus until reselected
// - Busy reads one during cycle, else zero
// - Pin guard mode is lock and protect-low
// - Most significant bit first, rise in, fall out
module sep_ctrl
  import sep_pkg::*;
#(
  parameter int unsigned TW_CYCLES = `SEP_TW_CYCLES
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic sclk_in,
  input wire logic cs_n_in,
  input wire logic mosi_in,
  input wire logic hold_n_in,
  input wire logic wp_n_in,
  output logic miso_out,
  output logic miso_oe_n_out,
  output logic standby_out,
  output logic busy_out,
  output logic [7:0] status_out,
  output logic mem_wr_start_out,
  output logic [15:0] mem_wr_addr_out
);

  localparam int CW = $clog2(TW_CYCLES + 1);
  function automatic logic [2:0] bin2gray(input logic [2:0] b);
    bin2gray = b ^ {1'b0, b[2:1]};
  endfunction

  function automatic logic [2:0] gray2bin(input logic [2:0] g);
    gray2bin = {g[2], g[2] ^ g[1], g[2] ^ g[1] ^ g[0]};
  endfunction

  // Link domain: serial clock, frame restarted by chip select
  // Frame start marker; preset while deselected so the next edge restarts
  logic frame_rst;
  logic fresh_q;
  assign frame_rst = cs_n_in | ~rst_n_in;
  always_ff @(posedge sclk_in or posedge frame_rst) begin
    if (frame_rst) begin
      fresh_q <= 1'b1;
    end else if (hold_n_in) begin
      fresh_q <= 1'b0;
    end
  end

  sep_frame_t frm_q;
  logic [7:0] sh_q;
  logic dead_q;
  logic stat_mode_q;
  logic tog_q;
  logic [7:0] in_byte;
  logic op_known;

  assign in_byte = {sh_q[6:0], mosi_in};
  assign op_known = (in_byte == `SEP_OP_ARM) || (in_byte == `SEP_OP_DISARM) ||
                    (in_byte == `SEP_OP_FETCH) || (in_byte == `SEP_OP_LOAD) ||
                    (in_byte == `SEP_OP_READ) || (in_byte == `SEP_OP_WRITE);
  // Hold low at a rising edge means the pause covers that edge
  always_ff @(posedge sclk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      frm_q <= '0;
      sh_q <= `SEP_BYTE_RST;
      dead_q <= 1'b0;
      stat_mode_q <= 1'b0;
      tog_q <= 1'b0;
    end else if (hold_n_in) begin
      if (fresh_q) begin
        sh_q <= {7'h00, mosi_in};
        frm_q.bit_cnt <= `SEP_BIT_FIRST;
        frm_q.byte_cnt <= `SEP_BYTES_NONE;
        dead_q <= 1'b0;
        stat_mode_q <= 1'b0;
        tog_q <= ~tog_q;
      end else if (!dead_q) begin
        sh_q <= in_byte;
        frm_q.bit_cnt <= frm_q.bit_cnt + 3'h1;
        if (frm_q.bit_cnt == `SEP_BIT_LAST) begin
          if (frm_q.byte_cnt != `SEP_BYTES_SAT) begin
            frm_q.byte_cnt <= frm_q.byte_cnt + 3'h1;
          end
          unique case (frm_q.byte_cnt)
            `SEP_BYTES_NONE: begin
              frm_q.op <= in_byte;
              dead_q <= ~op_known;
              stat_mode_q <= (in_byte == `SEP_OP_FETCH);
            end
            `SEP_BYTES_OP: begin
              frm_q.addr[15:8] <= in_byte;
              frm_q.dat <= in_byte;
            end
            `SEP_BYTES_ADDR_LO: begin
              frm_q.addr[7:0] <= in_byte;
              frm_q.dat <= in_byte;
            end
            default: begin
              frm_q.dat <= in_byte;
            end
          endcase
        end
      end
    end
  end

  // Output bit index steps on falling edges; held as gray for the crossing
  logic oen_q;
  logic [2:0] oidx_q;
  logic [2:0] ogray_q;

  always_ff @(negedge sclk_in or posedge frame_rst) begin
    if (frame_rst) begin
      oen_q <= 1'b0;
      oidx_q <= `SEP_BIT_ZERO;
      ogray_q <= `SEP_BIT_ZERO;
    end else if (hold_n_in && !fresh_q && stat_mode_q) begin
      if (!oen_q) begin
        oen_q <= 1'b1;
        oidx_q <= `SEP_OIDX_FIRST;
        ogray_q <= bin2gray(`SEP_OIDX_FIRST);
      end else begin
        oidx_q <= oidx_q - 3'h1;
        ogray_q <= bin2gray(oidx_q - 3'h1);
      end
    end
  end

  // Core domain
  sep_sync_t raw;
  sep_sync_t sync1_q;
  sep_sync_t sync2_q;

  assign raw = '{cs_n: cs_n_in, sclk: sclk_in, hold_n: hold_n_in, wp_n: wp_n_in,
                 tog: tog_q, oen: oen_q, ogray: ogray_q};

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      // Select reads low here so only a real high on the pin qualifies selection
      sync1_q <= '{cs_n: 1'b0, sclk: 1'b0, hold_n: 1'b1, wp_n: 1'b1,
                   tog: 1'b0, oen: 1'b0, ogray: 3'h0};
      sync2_q <= '{cs_n: 1'b0, sclk: 1'b0, hold_n: 1'b1, wp_n: 1'b1,
                   tog: 1'b0, oen: 1'b0, ogray: 3'h0};
    end else begin
      sync1_q <= raw;
      sync2_q <= sync1_q;
    end
  end

  logic cs_prev_q;
  logic seen_high_q;
  logic frame_ok_q;
  logic paused_q;
  logic last_tog_q;
  logic cs_rise;
  logic cs_fall;
  logic exec;

  assign cs_rise = ~cs_prev_q & sync2_q.cs_n;
  assign cs_fall = cs_prev_q & ~sync2_q.cs_n;
  // Link frame is static once the release is seen, so it is read as is
  assign exec = cs_rise & frame_ok_q & (sync2_q.tog != last_tog_q);
  // Selection qualifies only after chip select has been seen high
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      cs_prev_q <= 1'b1;
      seen_high_q <= 1'b0;
      frame_ok_q <= 1'b0;
      last_tog_q <= 1'b0;
    end else begin
      cs_prev_q <= sync2_q.cs_n;
      if (sync2_q.cs_n) begin
        seen_high_q <= 1'b1;
      end
      if (cs_fall) begin
        frame_ok_q <= seen_high_q;
      end else if (cs_rise) begin
        frame_ok_q <= 1'b0;
      end
      if (cs_rise) begin
        last_tog_q <= sync2_q.tog;
      end
    end
  end

  // Pause level follows hold only while the clock rests low
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      paused_q <= 1'b0;
    end else if (sync2_q.cs_n) begin
      paused_q <= 1'b0;
    end else if (!sync2_q.sclk) begin
      paused_q <= ~sync2_q.hold_n;
    end
  end

  sep_state_t state_q;
  logic [CW-1:0] cnt_q;
  logic kind_load_q;
  logic arm_q;
  logic [1:0] guard_q;
  logic lock_q;
  logic [1:0] pend_guard_q;
  logic pend_lock_q;
  logic pin_guard_mode;
  logic soft_guard_mode;
  logic guarded;
  logic [7:0] status;
  logic frame_whole;
  logic do_arm;
  logic do_disarm;
  logic do_load;
  logic do_write;
  logic cyc_done;

  assign pin_guard_mode = lock_q & ~sync2_q.wp_n;
  assign soft_guard_mode = ~pin_guard_mode;
  assign frame_whole = (frm_q.bit_cnt == `SEP_BIT_ZERO);

  always_comb begin
    unique case (guard_q)
      `SEP_GUARD_QTR: guarded = frm_q.addr >= `SEP_BASE_QTR;
      `SEP_GUARD_HALF: guarded = frm_q.addr >= `SEP_BASE_HALF;
      `SEP_GUARD_ALL: guarded = frm_q.addr >= `SEP_BASE_ALL;
      default: guarded = 1'b0;
    endcase
  end

  always_comb begin
    status = 8'h00;
    status[`SEP_SR_BUSY] = (state_q == SEP_BUSY);
    status[`SEP_SR_ARM] = arm_q;
    status[`SEP_SR_GLO] = guard_q[0];
    status[`SEP_SR_GHI] = guard_q[1];
    status[`SEP_SR_LOCK] = lock_q;
  end

  // Only one instruction per frame; nothing but status reads while busy
  always_comb begin
    do_arm = 1'b0;
    do_disarm = 1'b0;
    do_load = 1'b0;
    do_write = 1'b0;
    if (exec && frame_whole && state_q == SEP_IDLE) begin
      unique case (frm_q.op)
        `SEP_OP_ARM: do_arm = (frm_q.byte_cnt == `SEP_BYTES_OP);
        `SEP_OP_DISARM: do_disarm = (frm_q.byte_cnt == `SEP_BYTES_OP);
        `SEP_OP_LOAD: do_load = (frm_q.byte_cnt == `SEP_BYTES_LOAD) && arm_q && soft_guard_mode;
        `SEP_OP_WRITE: do_write = (frm_q.byte_cnt == `SEP_BYTES_WRITE) && arm_q && !guarded;
        default: ;
      endcase
    end
  end

  assign cyc_done = (state_q == SEP_BUSY) && (cnt_q == '0);
  // Self-timed cycle
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      state_q <= SEP_IDLE;
      cnt_q <= '0;
      kind_load_q <= 1'b0;
      pend_guard_q <= `SEP_GUARD_RST;
      pend_lock_q <= `SEP_LOCK_RST;
    end else begin
      unique case (state_q)
        SEP_IDLE: begin
          if (do_load || do_write) begin
            state_q <= SEP_BUSY;
            cnt_q <= CW'(TW_CYCLES - 1);
            kind_load_q <= do_load;
            pend_guard_q <= {frm_q.dat[`SEP_SR_GHI], frm_q.dat[`SEP_SR_GLO]};
            pend_lock_q <= frm_q.dat[`SEP_SR_LOCK];
          end
        end
        SEP_BUSY: begin
          if (cyc_done) begin
            state_q <= SEP_IDLE;
          end else begin
            cnt_q <= cnt_q - CW'(1);
          end
        end
      endcase
    end
  end

  // Non-volatile bits take their new value at the end of a status load
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      guard_q <= `SEP_GUARD_RST;
      lock_q <= `SEP_LOCK_RST;
    end else if (cyc_done && kind_load_q) begin
      guard_q <= pend_guard_q;
      lock_q <= pend_lock_q;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      arm_q <= 1'b0;
    end else if (do_arm) begin
      arm_q <= 1'b1;
    end else if (do_disarm || cyc_done) begin
      arm_q <= 1'b0;
    end
  end

  // Outputs, all registered
  logic drive;
  assign drive = ~sync2_q.cs_n & frame_ok_q & ~paused_q & sync2_q.oen;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      miso_out <= 1'b0;
      miso_oe_n_out <= 1'b1;
    end else begin
      miso_oe_n_out <= ~drive;
      miso_out <= drive & status[gray2bin(sync2_q.ogray)];
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      standby_out <= 1'b0;
      busy_out <= 1'b0;
      status_out <= 8'h00;
    end else begin
      standby_out <= sync2_q.cs_n & (state_q == SEP_IDLE);
      busy_out <= (state_q == SEP_BUSY);
      status_out <= status;
    end
  end

  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      mem_wr_start_out <= 1'b0;
      mem_wr_addr_out <= `SEP_ADDR_RST;
    end else begin
      mem_wr_start_out <= do_write;
      if (do_write) begin
        mem_wr_addr_out <= frm_q.addr;
      end
    end
  end

endmodule
`default_nettype wire

/* testbench/sep_ctrl_checker.sv */
// Port assertions of the serial EEPROM protection controller
`timescale 1ns/1ps
`default_nettype none
module sep_ctrl_checker #(
  parameter int unsigned TW_CYCLES = 1000
) (
  input wire logic core_clk_in,
  input wire logic rst_n_in,
  input wire logic cs_n_in,
  input wire logic miso_out,
  input wire logic miso_oe_n_out,
  input wire logic standby_out,
  input wire logic busy_out,
  input wire logic [7:0] status_out,
  input wire logic mem_wr_start_out,
  input wire logic [15:0] mem_wr_addr_out
);
  int unsigned busy_cnt_q;
  logic guarded;
  always_ff @(posedge core_clk_in or negedge rst_n_in) begin
    if (!rst_n_in) busy_cnt_q <= 0;
    else busy_cnt_q <= busy_out ? busy_cnt_q + 1 : 0;
  end
  assign guarded = status_out[3] ? (status_out[2] | mem_wr_addr_out[15]) :
                   (status_out[2] & (&mem_wr_addr_out[15:14]));
  default clocking cb @(posedge core_clk_in);
  endclocking
  default disable iff (!rst_n_in);
  property p_quiet_out;
    miso_oe_n_out |-> !miso_out;
  endproperty
  a_quiet_out: assert property (p_quiet_out) else $error("miso active while off");
  property p_desel_float;
    cs_n_in [*6] |-> miso_oe_n_out;
  endproperty
  a_desel_float: assert property (p_desel_float) else $error("output on while deselected");
  property p_standby;
    (cs_n_in && !busy_out) [*8] |-> standby_out;
  endproperty
  a_standby: assert property (p_standby) else $error("no standby when idle");
  property p_busy_bit;
    status_out[0] == busy_out && !(busy_out && standby_out);
  endproperty
  a_busy_bit: assert property (p_busy_bit) else $error("busy bit or standby wrong");
  property p_start_armed;
    $rose(mem_wr_start_out) |-> $past(status_out[1]) && !$past(busy_out);
  endproperty
  a_start_armed: assert property (p_start_armed) else $error("write started unarmed");
  property p_start_pulse;
    mem_wr_start_out |-> ##1 !mem_wr_start_out ##[0:1] busy_out;
  endproperty
  a_start_pulse: assert property (p_start_pulse) else $error("start pulse or busy wrong");
  property p_start_guard;
    mem_wr_start_out |-> !guarded;
  endproperty
  a_start_guard: assert property (p_start_guard) else $error("write into guarded area");
  property p_arm_clear;
    $fell(busy_out) |-> ##[0:1] !status_out[1];
  endproperty
  a_arm_clear: assert property (p_arm_clear) else $error("arm latch kept after cycle");
  property p_nv_hold;
    $changed(status_out[7:2]) |-> $fell(busy_out);
  endproperty
  a_nv_hold: assert property (p_nv_hold) else $error("guard bits changed early");
  property p_busy_len;
    $fell(busy_out) |-> busy_cnt_q >= TW_CYCLES - 1 && busy_cnt_q <= TW_CYCLES + 1;
  endproperty
  a_busy_len: assert property (p_busy_len) else $error("busy length wrong");
endmodule
`default_nettype wire

/* testbench/sep_spi_master.sv */
// Serial bus master model for the controller's link
`timescale 1ns/1ps
`default_nettype none
module sep_spi_master (
  output logic sclk_out,
  output logic cs_n_out,
  output logic mosi_out,
  output logic hold_n_out,
  input wire logic miso_in,
  input wire logic miso_oe_n_in
);
  logic last_q = 1'b0;
  logic oe_seen = 1'b0;
  logic hold_oe = 1'b0;
  // Floating line shows the inverse of the last driven bit
  wire logic line = miso_oe_n_in ? ~last_q : miso_in;
  // Select starts low: a power-up hazard
  initial begin
    sclk_out = 1'b0;
    cs_n_out = 1'b0;
    mosi_out = 1'b0;
    hold_n_out = 1'b1;
  end
  always @(miso_in, miso_oe_n_in) if (!miso_oe_n_in) last_q = miso_in;
  always @(negedge miso_oe_n_in) oe_seen = 1'b1;
  task automatic frame(input logic [39:0] d, input int n, input int half, input int hold_at,
                       input bit abort, output logic [7:0] rd);
    rd = 8'h00;
    oe_seen = 1'b0;
    cs_n_out = 1'b0;
    #20;
    for (int i = 0; i < n; i++) begin
      mosi_out = d[n-1-i];
      #(half) sclk_out = 1'b1;
      #(half);
      if (i >= 8) rd = {rd[6:0], line};
      sclk_out = 1'b0;
      if (i == hold_at) begin
        #4 hold_n_out = 1'b0;
        #20 hold_oe = miso_oe_n_in;
        sclk_out = 1'b1;
        #6 sclk_out = 1'b0;
        mosi_out = ~mosi_out;
        #6;
        if (abort) begin
          cs_n_out = 1'b1;
          #20 hold_n_out = 1'b1;
          #40;
          return;
        end
        hold_n_out = 1'b1;
        #20;
      end
    end
    #(half / 2) cs_n_out = 1'b1;
    mosi_out = ~mosi_out;
    #40;
  endtask
endmodule
`default_nettype wire

/* testbench/sep_ctrl_bench.sv */
// Self-checking bench of the serial EEPROM protection controller
`timescale 1ns/1ps
`default_nettype none
`include "sep_defs.svh"
module sep_ctrl_bench;
  localparam int TW = 20;
  logic core_clk = 1'b0;
  logic rst_n = 1'b0;
  logic wp_n = 1'b1;
  logic [16:0] lfsr = 17'h15f31;
  logic [7:0] rd_v;
  wire logic sclk, cs_n, mosi, hold_n, miso, miso_oe_n, standby, busy, wr_start;
  wire logic [7:0] status;
  wire logic [15:0] wr_addr;
  int fail_count = 0;
  int n_compared = 0;
  int starts = 0;
  int arm = 0;
  int grd = 0;
  int lock = 0;
  logic [15:0] bases [4] = '{`SEP_BASE_QTR, `SEP_BASE_QTR, `SEP_BASE_HALF, `SEP_BASE_ALL};
  initial forever #2 core_clk = ~core_clk;
  sep_ctrl #(.TW_CYCLES(TW)) i_sep_ctrl (.core_clk_in(core_clk), .rst_n_in(rst_n), .sclk_in(sclk),
    .cs_n_in(cs_n), .mosi_in(mosi), .hold_n_in(hold_n), .wp_n_in(wp_n), .miso_out(miso),
    .miso_oe_n_out(miso_oe_n), .standby_out(standby), .busy_out(busy), .status_out(status),
    .mem_wr_start_out(wr_start), .mem_wr_addr_out(wr_addr));
  sep_spi_master i_sep_spi_master (.sclk_out(sclk), .cs_n_out(cs_n), .mosi_out(mosi),
    .hold_n_out(hold_n), .miso_in(miso), .miso_oe_n_in(miso_oe_n));
  always @(posedge core_clk) if (wr_start === 1'b1) starts <= starts + 1;
  function automatic logic [16:0] nxt(input logic [16:0] v);
    return {v[15:0], v[16] ^ v[13]};
  endfunction
  task automatic chk_val(input logic [15:0] got, input logic [15:0] exp);
    n_compared++;
    if (got !== exp) begin
      fail_count++;
      $display("unexpected at %0t: got %h want %h", $time, got, exp);
    end
  endtask
  task automatic chk_status;
    chk_val({8'h00, status}, {8'h00, lock[0], 3'h0, grd[1:0], arm[0], 1'b0});
  endtask
  task automatic go(input logic [39:0] d, input int n, input int hold_at = -1, input bit ab = 1'b0);
    i_sep_spi_master.frame(d, n, 6, hold_at, ab, rd_v);
  endtask
  task automatic idle;
    repeat (8) @(posedge core_clk);
    for (int k = 0; k < 100 && busy !== 1'b0; k++) @(posedge core_clk);
  endtask
  task automatic wr(input logic [15:0] a);
    int s0;
    logic p;
    s0 = starts;
    p = grd == 3 || (grd == 2 && a[15]) || (grd == 1 && a[15:14] == 2'b11);
    lfsr = nxt(lfsr);
    go(`SEP_OP_ARM, 8);
    arm = 1;
    go({`SEP_OP_WRITE, a, lfsr[7:0]}, 32);
    chk_val(16'(starts - s0), {15'h0, !p});
    chk_val({15'h0, busy}, {15'h0, !p});
    if (!p) chk_val(wr_addr, a);
    idle();
    if (!p) arm = 0;
    chk_status();
  endtask
  task automatic ld(input logic [7:0] v, input int hold_at, input bit ok);
    go(`SEP_OP_ARM, 8);
    arm = 1;
    go({`SEP_OP_LOAD, v}, 16, hold_at);
    chk_val({15'h0, busy}, {15'h0, ok});
    idle();
    if (ok) begin
      arm = 0;
      grd = v[3:2];
      lock = v[7];
    end
    chk_status();
  endtask
  task automatic give_verdict;
    $display("compared %0d mismatches %0d", n_compared, fail_count);
    if (fail_count == 0 && n_compared > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    #100000;
    fail_count++;
    give_verdict();
  end
  initial begin
    // Frame spans reset with select low from power-up
    fork
      go(`SEP_OP_ARM, 8);
      begin
        repeat (6) @(posedge core_clk);
        rst_n <= 1'b1;
      end
    join
    idle();
    chk_status();
    go(`SEP_OP_ARM, 8);
    arm = 1;
    chk_status();
    go(`SEP_OP_DISARM, 8);
    arm = 0;
    chk_status();
    go({`SEP_OP_WRITE, 24'h000010}, 32);
    chk_val(16'(starts), 16'h0);
    go(`SEP_OP_ARM, 8, 3, 1'b1);
    chk_status();
    go({8'hff, `SEP_OP_ARM}, 16);
    chk_val({15'h0, i_sep_spi_master.oe_seen}, 16'h0);
    chk_status();
    go(`SEP_OP_ARM, 8);
    arm = 1;
    go({`SEP_OP_WRITE, 24'h00105a, 1'b0}, 33);
    chk_val(16'(starts), 16'h0);
    idle();
    chk_status();
    for (int g = 0; g < 4; g++) begin
      ld(8'(g << 2), 10, 1'b1);
      wr(bases[g] - 16'h0001);
      wr(bases[g]);
      wr(lfsr[16:1]);
    end
    ld(8'h84, -1, 1'b1);
    @(posedge core_clk) wp_n <= 1'b0;
    ld(8'h00, -1, 1'b0);
    i_sep_spi_master.frame({`SEP_OP_FETCH, 8'h00}, 16, 12, 10, 1'b0, rd_v);
    chk_val({8'h00, rd_v}, {8'h00, lock[0], 3'h0, grd[1:0], arm[0], 1'b0});
    chk_val({15'h0, i_sep_spi_master.hold_oe}, 16'h1);
    go({`SEP_OP_READ, 16'h0000}, 24);
    chk_val({15'h0, i_sep_spi_master.oe_seen}, 16'h0);
    // Reset mid-run: a frame begun inside it must not execute
    @(posedge core_clk) rst_n <= 1'b0;
    fork
      go(`SEP_OP_ARM, 8);
      begin
        repeat (2) @(posedge core_clk);
        rst_n <= 1'b1;
      end
    join
    idle();
    arm = 0;
    grd = 0;
    lock = 0;
    chk_status();
    give_verdict();
  end
endmodule
bind sep_ctrl sep_ctrl_checker #(.TW_CYCLES(TW_CYCLES)) i_sep_ctrl_checker (
  .core_clk_in(core_clk_in), .rst_n_in(rst_n_in), .cs_n_in(cs_n_in), .miso_out(miso_out),
  .miso_oe_n_out(miso_oe_n_out), .standby_out(standby_out), .busy_out(busy_out),
  .status_out(status_out), .mem_wr_start_out(mem_wr_start_out), .mem_wr_addr_out(mem_wr_addr_out));
`default_nettype wire
